// ### logic/reset_power_mode_sequencer.sv
/*
 * reset and power-mode sequencer: reset sources, start-up delays, idle and
 * power-down entry and wake-up, system clock source register.
 * assumes i_core_clk is the oscillator clock, pins arrive asynchronously,
 * and the cpu/timer/interrupt logic lives outside and uses the outputs.
 */
// Local design decision: the address-and-strobe port.
// Function
// - system control bits 7:6 choose timer 1 clock source
// - system control bits 5:4 choose timer 0 clock source
// - timer 1: divided clock, pin, fetch pulse, peripheral clock
// - timer 0: divided clock, pin, instruction pulse, peripheral clock
// - bit 0 disables oscillator, bit 1 selects comparator, bits 3:2 unused
// - watchdog expiry resets the chip like an external reset
// - internal reset drives pin low 1024 cycles, released 16 before fetch
// - idle stops execution, clock and peripherals keep running
// - power-down stops oscillator so blocks on it halt; pin-clocked timers keep counting
// - idle starts right after instruction setting power control bit 0
// - power-down starts right after instruction setting power control bit 1
// - idle and power-down keep ram and register contents
// - enabled interrupt clears idle bit and resumes after idle instruction
// - only external irqs or pin-clocked timers clear power-down bit
// - hardware reset ends idle or power-down, registers to defaults
// - power control bits 7:2 reserved zero, resets to zero
// - power-on start waits 1024 plus 16 cycles before execution
// - external reset does not reload counter, start within 16400 cycles
// - watchdog reset holds pin low 1024 cycles, code 16 later
// - power-down wake delay shortened by wake-up count register
// - wake delay 1024 clocks at 00h down to 4 at ffh
`timescale 1ns/1ps
`include "rpms_map.svh"

module reset_power_mode_sequencer
    import rpms_pkg::*;
#(
    parameter int NUM_EXT_IRQ = 10
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // reset pin, open drain
    input wire logic i_reset_pin,
    output logic o_reset_pin_out,
    output logic o_reset_pin_oe,
    // reset sources and wake events
    input wire logic i_watchdog_expired,
    input wire logic i_irq_pending,
    input wire logic [NUM_EXT_IRQ-1:0] i_ext_irq,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    // cpu handshake
    input wire logic i_instr_done,
    input wire logic i_code_fetch_pulse,
    input wire logic i_instruction_issue_pulse,
    output logic o_cpu_run,
    output logic o_cpu_reset,
    output logic o_wake_irq,
    // clocking controls
    input wire logic i_div_clk,
    input wire logic i_per_clk,
    input wire logic i_timer0_pin,
    input wire logic i_timer1_pin,
    output logic o_timer0_clk,
    output logic o_timer1_clk,
    output logic o_osc_disable,
    output logic o_osc_stop,
    output logic o_comparator_sel,
    output logic o_idle,
    output logic o_powerdown
);
    localparam logic [10:0] PIN_LOW_CNT = 11'(`PIN_LOW_CYCLES);
    localparam logic [10:0] GAP_CNT = 11'(`FETCH_GAP_CYCLES);
    localparam logic [14:0] EXT_MAX_CNT = 15'(`EXT_MAX_CYCLES);

    logic rst_sync1_r;
    logic rst_sync2_r;
    logic rst_b;
    logic pin_meta_r;
    logic pin_sync_r;
    logic wd_meta_r;
    logic wd_sync_r;
    logic [NUM_EXT_IRQ-1:0] irq_meta_r;
    logic [NUM_EXT_IRQ-1:0] irq_sync_r;
    logic [7:0] power_mode_control_r;
    logic [7:0] system_clock_source_control_r;
    logic [7:0] wakeup_delay_count_r;
    seq_state_t state_r;
    logic [10:0] count_r;
    logic [14:0] ext_cnt_r;
    logic ext_seen_r;
    logic pin_drive_r;
    logic drive_d1_r;
    logic drive_d2_r;
    logic pwr_wr;
    logic sys_wr;
    logic wake_wr;
    logic pd_wake;
    logic idle_wake;
    logic ext_reset;
    logic [10:0] wake_delay;
    logic [7:0] rdata_nxt;
    timer_src_t t0_src;
    timer_src_t t1_src;

    // reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    assign rst_b = rst_sync2_r;

    // pin and cross-domain event synchronisers
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            wd_meta_r <= 1'b0;
            wd_sync_r <= 1'b0;
            irq_meta_r <= '0;
            irq_sync_r <= '0;
        end else begin
            pin_meta_r <= i_reset_pin;
            pin_sync_r <= pin_meta_r;
            wd_meta_r <= i_watchdog_expired;
            wd_sync_r <= wd_meta_r;
            irq_meta_r <= i_ext_irq;
            irq_sync_r <= irq_meta_r;
        end
    end

    // the line needs two sync flops to read high again after we let go, so
    // our own release must not look like another party pulling it
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_d1_r <= 1'b0;
            drive_d2_r <= 1'b0;
        end else begin
            drive_d1_r <= pin_drive_r;
            drive_d2_r <= drive_d1_r;
        end
    end

    // pin low while we are not driving it means another party asks for reset
    assign ext_reset = !pin_sync_r
        && !pin_drive_r
        && !drive_d1_r
        && !drive_d2_r;

    assign t1_src = timer_src_t'(system_clock_source_control_r[`SYS_T1_SRC_HI:`SYS_T1_SRC_LO]);
    assign t0_src = timer_src_t'(system_clock_source_control_r[`SYS_T0_SRC_HI:`SYS_T0_SRC_LO]);

    // power-down wake only from external irqs or pin-clocked timers
    assign pd_wake = (|irq_sync_r)
        || (i_timer0_ovf && t0_src == SRC_EXT_PIN)
        || (i_timer1_ovf && t1_src == SRC_EXT_PIN);
    assign idle_wake = i_irq_pending;

    // (1024-4)/255 per step, 1024 at 00h down to 4 at ffh
    // integer division rounds down between the end points; the product
    // is widened first so it cannot wrap
    always_comb begin
        wake_delay = 11'(`WAKE_MAX_CYCLES)
            - 11'((32'(wakeup_delay_count_r) * (`WAKE_MAX_CYCLES - `WAKE_STEP)) / 255);
    end

    // one write decode per register keeps the update blocks short
    assign pwr_wr = i_reg_wr && i_reg_addr == `PWR_CTRL_ADDR;
    assign sys_wr = i_reg_wr && i_reg_addr == `SYS_CTRL_ADDR;
    assign wake_wr = i_reg_wr && i_reg_addr == `WAKE_CNT_ADDR;

    // power mode control register
    // a software write wins over the hardware clear in the same cycle
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode_control_r <= 8'(`PWR_CTRL_RST);
        end else if (ext_reset || wd_sync_r) begin
            power_mode_control_r <= 8'(`PWR_CTRL_RST);
        end else if (pwr_wr) begin
            power_mode_control_r <= {6'h00, i_reg_wdata[1:0]};
        end else if (state_r == ST_IDLE && idle_wake) begin
            power_mode_control_r[`PWR_IDLE_BIT] <= 1'b0;
        end else if (state_r == ST_POWERDOWN && pd_wake) begin
            power_mode_control_r <= 8'h00;
        end
    end

    // system control and wake count registers
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            system_clock_source_control_r <= 8'(`SYS_CTRL_RST);
            wakeup_delay_count_r <= 8'(`WAKE_CNT_RST);
        end else if (ext_reset || wd_sync_r) begin
            system_clock_source_control_r <= 8'(`SYS_CTRL_RST);
            wakeup_delay_count_r <= 8'(`WAKE_CNT_RST);
        end else if (sys_wr) begin
            system_clock_source_control_r <= {i_reg_wdata[7:4], 2'b00, i_reg_wdata[1:0]};
        end else if (wake_wr) begin
            wakeup_delay_count_r <= i_reg_wdata;
        end
    end

    // read port, one cycle latency
    always_comb begin
        if (i_reg_addr == `PWR_CTRL_ADDR) begin
            rdata_nxt = power_mode_control_r;
        end else if (i_reg_addr == `SYS_CTRL_ADDR) begin
            rdata_nxt = system_clock_source_control_r;
        end else if (i_reg_addr == `WAKE_CNT_ADDR) begin
            rdata_nxt = wakeup_delay_count_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_nxt;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // sequencer
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_POR_WAIT;
            count_r <= PIN_LOW_CNT + GAP_CNT;
            pin_drive_r <= 1'b0;
        end else if (wd_sync_r && !pin_drive_r) begin
            state_r <= ST_RESET_HOLD;
            count_r <= PIN_LOW_CNT;
            pin_drive_r <= 1'b1;
        end else if (ext_reset) begin
            // counter not reloaded: execution follows the pin release
            state_r <= ST_FETCH_GAP;
            count_r <= GAP_CNT;
        end else begin
            case (state_r)
                ST_POR_WAIT: begin
                    // settling time and fetch gap run as one count
                    if (count_r <= 11'd1) begin
                        state_r <= ST_RUN;
                    end
                    count_r <= count_r - 11'd1;
                end
                ST_RESET_HOLD: begin
                    if (count_r <= 11'd1) begin
                        pin_drive_r <= 1'b0;
                        state_r <= ST_FETCH_GAP;
                        count_r <= GAP_CNT;
                    end else begin
                        count_r <= count_r - 11'd1;
                    end
                end
                ST_FETCH_GAP: begin
                    if (count_r <= 11'd1) begin
                        state_r <= ST_RUN;
                    end
                    count_r <= count_r - 11'd1;
                end
                ST_RUN: begin
                    // both bits set falls to power-down
                    if (i_instr_done && power_mode_control_r[`PWR_DOWN_BIT]) begin
                        state_r <= ST_POWERDOWN;
                    end else if (i_instr_done && power_mode_control_r[`PWR_IDLE_BIT]) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // clock keeps running here, only execution stops
                    if (idle_wake) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_POWERDOWN: begin
                    // the shortened delay applies to this wake only,
                    // never to a start after reset
                    if (pd_wake) begin
                        state_r <= ST_WAKE_WAIT;
                        count_r <= wake_delay;
                    end
                end
                default: begin
                    if (count_r <= 11'd1) begin
                        state_r <= ST_RUN;
                    end
                    count_r <= count_r - 11'd1;
                end
            endcase
        end
    end

    // bound on external reset start-up, counted from pin assertion
    // limitation: the count wraps while the pin is held, stops at run or at the bound after release, and is never acted on
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_cnt_r <= '0;
            ext_seen_r <= 1'b0;
        end else if (ext_reset) begin
            ext_cnt_r <= ext_seen_r ? ext_cnt_r + 15'd1 : 15'd0;
            ext_seen_r <= 1'b1;
        end else if (state_r == ST_RUN || ext_cnt_r >= EXT_MAX_CNT) begin
            ext_seen_r <= 1'b0;
        end else if (ext_seen_r) begin
            ext_cnt_r <= ext_cnt_r + 15'd1;
        end
    end

    assign o_reset_pin_out = 1'b0;
    assign o_reset_pin_oe = pin_drive_r;
    // cpu stays in reset through every start-up phase and while the pin is held
    assign o_cpu_reset = (state_r == ST_POR_WAIT)
        || (state_r == ST_RESET_HOLD)
        || (state_r == ST_FETCH_GAP)
        || ext_reset;
    // registers untouched while halted, cpu just stops
    assign o_cpu_run = state_r == ST_RUN && !ext_reset;
    assign o_idle = state_r == ST_IDLE;
    assign o_powerdown = state_r == ST_POWERDOWN;
    assign o_osc_stop = state_r == ST_POWERDOWN;
    assign o_wake_irq = (state_r == ST_IDLE && idle_wake)
        || (state_r == ST_POWERDOWN && pd_wake);
    assign o_osc_disable = system_clock_source_control_r[`SYS_OSC_DIS_BIT];
    assign o_comparator_sel = system_clock_source_control_r[`SYS_CMP_SEL_BIT];

    // timer source muxes; pin source still counts in power-down
    always_comb begin
        case (t1_src)
            SRC_DIV_CLK: begin
                o_timer1_clk = i_div_clk;
            end
            SRC_EXT_PIN: begin
                o_timer1_clk = i_timer1_pin;
            end
            SRC_CPU_PULSE: begin
                o_timer1_clk = i_code_fetch_pulse;
            end
            default: begin
                o_timer1_clk = i_per_clk;
            end
        endcase
        case (t0_src)
            SRC_DIV_CLK: begin
                o_timer0_clk = i_div_clk;
            end
            SRC_EXT_PIN: begin
                o_timer0_clk = i_timer0_pin;
            end
            SRC_CPU_PULSE: begin
                o_timer0_clk = i_instruction_issue_pulse;
            end
            default: begin
                o_timer0_clk = i_per_clk;
            end
        endcase
    end
endmodule

// ### shared/rpms_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * reset and power-mode sequencer; assumes inclusion by bare name
 */
`ifndef RPMS_MAP_SVH
`define RPMS_MAP_SVH
`define PWR_CTRL_ADDR 8'h87
`define SYS_CTRL_ADDR 8'hb4
`define WAKE_CNT_ADDR 8'hdd
`define PWR_CTRL_RST 8'h00
`define SYS_CTRL_RST 8'h00
`define WAKE_CNT_RST 8'h00
`define PWR_IDLE_BIT 0
`define PWR_DOWN_BIT 1
`define SYS_OSC_DIS_BIT 0
`define SYS_CMP_SEL_BIT 1
`define SYS_T0_SRC_LO 4
`define SYS_T0_SRC_HI 5
`define SYS_T1_SRC_LO 6
`define SYS_T1_SRC_HI 7
`define PIN_LOW_CYCLES 1024
`define FETCH_GAP_CYCLES 16
`define WAKE_MAX_CYCLES 1024
`define WAKE_STEP 4
`define EXT_MAX_CYCLES 16400
`endif

// ### shared/rpms_pkg.sv
/*
 * types of the reset and power-mode sequencer; no other assumptions
 */
package rpms_pkg;
    typedef enum logic [1:0] {
        SRC_DIV_CLK,
        SRC_EXT_PIN,
        SRC_CPU_PULSE,
        SRC_PER_CLK
    } timer_src_t;

    typedef enum {
        ST_POR_WAIT,
        ST_RESET_HOLD,
        ST_FETCH_GAP,
        ST_RUN,
        ST_IDLE,
        ST_POWERDOWN,
        ST_WAKE_WAIT
    } seq_state_t;
endpackage

// ### verification/reset_power_mode_sequencer_properties.sv
/* port checker of the reset and power-mode sequencer;
   assumes binding to the top module, whose ports it reads */
`timescale 1ns/1ps
module rpms_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    // reset and cpu
    input wire logic o_reset_pin_out,
    input wire logic o_reset_pin_oe,
    input wire logic i_watchdog_expired,
    input wire logic i_irq_pending,
    input wire logic i_instr_done,
    input wire logic o_cpu_run,
    input wire logic o_wake_irq,
    // clocking
    input wire logic i_div_clk,
    input wire logic i_per_clk,
    input wire logic i_timer1_pin,
    input wire logic i_code_fetch_pulse,
    input wire logic o_timer1_clk,
    input wire logic o_osc_disable,
    input wire logic o_comparator_sel,
    input wire logic o_osc_stop,
    input wire logic o_idle,
    input wire logic o_powerdown
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic [10:0] oe_cnt_r;
    logic t1_exp;
    // consecutive cycles the device has held the reset line
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_cnt_r <= 11'h000;
        end else begin
            oe_cnt_r <= o_reset_pin_oe ? oe_cnt_r + 11'h001 : 11'h000;
        end
    end
    always_comb begin
        case (o_reg_rdata[7:6])
            2'h0: t1_exp = i_div_clk;
            2'h1: t1_exp = i_timer1_pin;
            2'h2: t1_exp = i_code_fetch_pulse;
            default: t1_exp = i_per_clk;
        endcase
    end
    property p_pin_low; o_reset_pin_out == 1'b0; endproperty
    property p_hold; $fell(o_reset_pin_oe) |-> oe_cnt_r == 11'h400; endproperty
    property p_gap; $fell(o_reset_pin_oe) |-> !o_cpu_run [*8] ##[4:12] o_cpu_run; endproperty
    property p_wdog; $rose(i_watchdog_expired) && o_cpu_run |-> ##[1:5] o_reset_pin_oe; endproperty
    property p_pwr_rsvd; i_reg_rd && i_reg_addr == 8'h87 |=> o_reg_rdata[7:2] == 6'h00; endproperty
    // read data and live outputs both come from the same register
    property p_sys_read;
        i_reg_rd && i_reg_addr == 8'hb4 |=> o_reg_rdata[3:2] == 2'h0 && o_timer1_clk == t1_exp
            && o_osc_disable == o_reg_rdata[0] && o_comparator_sel == o_reg_rdata[1];
    endproperty
    property p_idle_entry; $rose(o_idle) |-> $past(i_instr_done) && !o_cpu_run && !o_osc_stop; endproperty
    property p_idle_wake; o_idle && i_irq_pending |-> o_wake_irq ##[1:3] !o_idle; endproperty
    property p_pd_stop; o_powerdown |-> o_osc_stop && !o_cpu_run && !o_idle; endproperty
    property p_pd_entry; $rose(o_powerdown) |-> $past(i_instr_done); endproperty
    a_pin_low: assert property (p_pin_low) else $error("reset pin driven high");
    a_hold: assert property (p_hold) else $error("reset line hold length");
    a_gap: assert property (p_gap) else $error("gap before start");
    a_wdog: assert property (p_wdog) else $error("watchdog not reset");
    a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("power reserved bits");
    a_sys_read: assert property (p_sys_read) else $error("system control");
    a_idle_entry: assert property (p_idle_entry) else $error("idle entry");
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
    a_pd_stop: assert property (p_pd_stop) else $error("power-down outputs");
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entry");
    c_idle_wake: cover property (o_idle && i_irq_pending);
    c_pd: cover property ($rose(o_powerdown));
    c_hold: cover property ($fell(o_reset_pin_oe));
endmodule
bind reset_power_mode_sequencer rpms_checker u_chk (.*);

// ### verification/reset_line_partner.sv
/* other party on the shared active-low reset line;
   assumes a board pull-up, so a released line reads high */
`timescale 1ns/1ps
module reset_line_partner (
    // device side
    input wire logic i_dev_oe,
    input wire logic i_dev_out,
    // bench request to pull the line
    input wire logic i_pull_req,
    // resolved line level
    output logic o_line
);
    always_comb begin
        if (i_pull_req) begin
            o_line = 1'b0;
        end else if (i_dev_oe) begin
            o_line = i_dev_out;
        end else begin
            o_line = 1'b1;
        end
    end
endmodule

// ### verification/tb_reset_power_mode_sequencer.sv
/* bench of the reset and power-mode sequencer;
   assumes the partner model resolves the shared reset line */
`timescale 1ns/1ps
module tb_reset_power_mode_sequencer;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wdog = 1'b0, irq = 1'b0, instr = 1'b0, t0_ovf = 1'b0, t1_ovf = 1'b0, pull = 1'b0;
    logic [9:0] ext = 10'h000;
    logic [5:0] src = 6'h00;
    logic pin, pin_out, pin_oe, run, cpu_rst, wake, t0_clk, t1_clk, osc_dis, stop, cmp, idle, pd;
    int n_fail = 0, n_checks = 0, cyc = 0;
    reset_power_mode_sequencer uut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_reset_pin(pin),
        .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe), .i_watchdog_expired(wdog),
        .i_irq_pending(irq), .i_ext_irq(ext), .i_timer0_ovf(t0_ovf), .i_timer1_ovf(t1_ovf),
        .i_instr_done(instr), .i_code_fetch_pulse(src[3]), .i_instruction_issue_pulse(src[4]),
        .o_cpu_run(run), .o_cpu_reset(cpu_rst), .o_wake_irq(wake), .i_div_clk(src[0]),
        .i_per_clk(src[5]), .i_timer0_pin(src[1]), .i_timer1_pin(src[2]),
        .o_timer0_clk(t0_clk), .o_timer1_clk(t1_clk), .o_osc_disable(osc_dis),
        .o_osc_stop(stop), .o_comparator_sel(cmp), .o_idle(idle), .o_powerdown(pd));
    reset_line_partner peer (.i_dev_oe(pin_oe), .i_dev_out(pin_out), .i_pull_req(pull),
        .o_line(pin));
    always #5 i_core_clk = ~i_core_clk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // whole run is near 2500 cycles
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_core_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_core_clk);
        rd <= 1'b0;
        #1 chk(rdata === exp, "read data");
    endtask
    task automatic pulse_instr;
        @(posedge i_core_clk);
        instr <= 1'b1;
        @(posedge i_core_clk);
        instr <= 1'b0;
        #1;
    endtask
    // cycles until a signal reaches a level, bounded
    task automatic cnt(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge i_core_clk);
            #1 n++;
        end
    endtask
    task automatic t_por;
        int n;
        cnt(run, 1'b1, 1100, n);
        chk(n >= 1040 && n <= 1048, "start-up delay");
        rreg(8'h87, 8'h00);
        rreg(8'hb4, 8'h00);
        rreg(8'h55, 8'h00);
    endtask
    task automatic t_sys;
        logic [1:0] e;
        int i1[4] = '{0, 2, 3, 5};
        int i0[4] = '{0, 1, 4, 5};
        for (int k = 0; k < 4; k++) begin
            e = k[1:0];
            wreg(8'hb4, {e, e, 4'hf});
            rreg(8'hb4, {e, e, 4'h3});
            chk(osc_dis === 1'b1 && cmp === 1'b1, "oscillator and comparator bits");
            for (int s = 0; s < 6; s++) begin
                @(posedge i_core_clk);
                src <= 6'h01 << s;
                #1 chk(t1_clk === (s == i1[k]) && t0_clk === (s == i0[k]), "timer source");
            end
        end
        wreg(8'hb4, 8'h00);
    endtask
    task automatic t_idle;
        int n;
        wreg(8'h87, 8'hfd);
        rreg(8'h87, 8'h01);
        chk(idle === 1'b0 && run === 1'b1, "idle before instruction end");
        pulse_instr();
        chk(idle === 1'b1 && run === 1'b0 && stop === 1'b0, "idle entry");
        @(posedge i_core_clk);
        irq <= 1'b1;
        @(posedge i_core_clk);
        irq <= 1'b0;
        cnt(run, 1'b1, 4, n);
        chk(run === 1'b1 && idle === 1'b0, "idle wake");
        rreg(8'h87, 8'h00);
    endtask
    task automatic t_pd;
        int n;
        wreg(8'hdd, 8'hcc);
        wreg(8'h87, 8'h03);
        pulse_instr();
        chk(pd === 1'b1 && stop === 1'b1 && run === 1'b0, "power-down entry");
        @(posedge i_core_clk);
        t0_ovf <= 1'b1;
        irq <= 1'b1;
        tick(6);
        #1 chk(pd === 1'b1, "wake by non-pin timer");
        t0_ovf <= 1'b0;
        irq <= 1'b0;
        ext <= 10'h200;
        cnt(run, 1'b1, 260, n);
        ext <= 10'h000;
        chk(n >= 208 && n <= 216, "wake-up delay");
        rreg(8'h87, 8'h00);
        wreg(8'hdd, 8'h00);
    endtask
    task automatic t_wdog;
        int n;
        wreg(8'hb4, 8'h50);
        @(posedge i_core_clk);
        wdog <= 1'b1;
        @(posedge i_core_clk);
        wdog <= 1'b0;
        cnt(pin_oe, 1'b1, 8, n);
        chk(pin === 1'b0 && run === 1'b0, "watchdog reset");
        cnt(pin_oe, 1'b0, 1100, n);
        chk(n == 1024, "reset line hold");
        cnt(run, 1'b1, 30, n);
        chk(n == 16, "gap before start");
        rreg(8'hb4, 8'h00);
    endtask
    task automatic t_ext;
        int n;
        wreg(8'h87, 8'h01);
        pulse_instr();
        pull <= 1'b1;
        tick(40);
        #1 chk(cpu_rst === 1'b1 && idle === 1'b0 && pin_oe === 1'b0, "external reset");
        pull <= 1'b0;
        cnt(run, 1'b1, 100, n);
        chk(n >= 16 && n <= 24, "external start-up");
        rreg(8'h87, 8'h00);
    endtask
    initial begin
        tick(2);
        i_rst_b <= 1'b1;
        t_por();
        t_sys();
        t_idle();
        t_pd();
        t_wdog();
        t_ext();
        end_sim();
    end
endmodule
